// ---- vref_pkg.sv ----
// Purpose: Shared constants and carriers for the reference select block
// Assumes: Avalon-MM byte addresses, 32-bit data, 8-bit ladder and latch registers, 4-bit select register
// Notes:   Register data sits in bits 7:0, status level in bits 14:8, other bits read zero
package vref_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [3:0] OFS_LADDER = 4'h0;
  localparam logic [3:0] OFS_LATCH  = 4'h4;
  localparam logic [3:0] OFS_SELECT = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;

  // ==========================================================
  // Field positions
  localparam int LAD_POWER_BIT  = 7;
  localparam int LAD_PIN_BIT    = 6;
  localparam int LAD_RANGE_BIT  = 5;
  localparam int LAD_SOURCE_BIT = 4;
  localparam int LAT_FIXED_BIT  = 0;
  localparam int SEL_CMP1_BIT   = 0;
  localparam int SEL_CMP2_BIT   = 1;
  localparam int SEL_ADCP_BIT   = 2;
  localparam int SEL_ADCN_BIT   = 3;

  // ==========================================================
  // Reset values and masks
  localparam logic [7:0] LADDER_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET  = 8'h00;
  localparam logic [3:0] SELECT_RESET = 4'h0;
  localparam logic [7:0] LATCH_RW_MASK = 8'hF1;

  // ==========================================================
  // Ladder level in 96ths of the source
  localparam logic [6:0] LOW_STEP   = 7'h04;
  localparam logic [6:0] HIGH_BASE  = 7'h18;
  localparam logic [6:0] HIGH_STEP  = 7'h03;

  // ==========================================================
  // Types
  typedef enum logic {BUS_IDLE, BUS_ACK} bus_e;
  typedef enum logic [1:0] {PIN2_IO, PIN2_LADDER, PIN2_VREF_NEG} pin2_mode_e;
  typedef enum logic {PIN3_IO, PIN3_VREF_POS} pin3_mode_e;
  typedef enum logic {POS_SUPPLY, POS_EXTERNAL} pos_src_e;
  typedef enum logic {NEG_GROUND, NEG_EXTERNAL} neg_src_e;

  typedef struct packed {
    logic       fixed_ref_on;
    logic       ladder_power;
    logic       ladder_current;
    logic       ladder_clamped;
    logic       range_low;
    logic       source_external;
    logic [3:0] tap;
    logic [6:0] level;
    logic       cmp1_ladder;
    logic       cmp2_ladder;
    pin2_mode_e pin2;
    pin3_mode_e pin3;
    pos_src_e   cmp_pos;
    neg_src_e   cmp_neg;
    pos_src_e   adc_pos;
    neg_src_e   adc_neg;
  } route_s;

endpackage

// ---- vref_select_ctl.sv ----
// Purpose: Control of fixed reference, resistor ladder and reference routing
// Assumes: One 10 MHz clock, Avalon-MM slave with one wait cycle
// Notes:   Every output is registered from the next-state copy
//
// Functional notes
// - Enable bit set switches fixed reference on
// - Fast oscillator running forces fixed reference on
// - Cmp1 select routes ladder, enables current unless ladder clamped
// - Cmp2 select routes ladder, enables current unless ladder clamped
// - Both selects clear stop ladder current
// - Ladder bit 7 powers ladder circuit
// - Ladder bit 6 drives ladder to pin two unless select bit 3 is set
// - Ladder bit 5 one selects low range
// - Ladder bit 4 selects external source
// - Tap gives tap/24 or quarter plus tap/32
// - Two config bits pick ADC references
// - Source bit and pin output remap references
// - Power off, low range, tap zero grounds output
//
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps

module vref_select_ctl (
  input  wire logic           clk,
  input  wire logic           reset_n,
  input  wire logic [3:0]     address,
  input  wire logic           read,
  input  wire logic           write,
  input  wire logic [31:0]    writedata,
  input  wire logic [3:0]     byteenable,
  output logic [31:0]         readdata,
  output logic                waitrequest,
  input  wire logic           fast_internal_osc_active,
  output vref_pkg::route_s    route
);

  // ==========================================================
  // State
  typedef struct packed {
    vref_pkg::bus_e   bus;
    logic             wait_req;
    logic [31:0]      rdata;
    logic [7:0]       ladder;
    logic [7:0]       latch;
    logic [3:0]       sel;
    vref_pkg::route_s rt;
  } ctl_s;

  ctl_s       state_r;
  ctl_s       state_nxt;
  logic [1:0] rst_sync_r;
  logic       rst_n;

  // ==========================================================
  // Reset release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ==========================================================
  // Helpers
  function automatic logic [6:0] ladder_level(
    input logic       low,
    input logic [3:0] tap
  );
    logic [6:0] t;
    t = {3'h0, tap};
    if (low) begin
      ladder_level = t * vref_pkg::LOW_STEP;
    end else begin
      ladder_level = vref_pkg::HIGH_BASE + t * vref_pkg::HIGH_STEP;
    end
  endfunction

  function automatic vref_pkg::route_s route_of(
    input logic [7:0] lad,
    input logic [7:0] lat,
    input logic [3:0] sel,
    input logic       osc
  );
    vref_pkg::route_s r;
    logic             pin_out;
    logic             cfg_p;
    logic             cfg_n;
    logic             ext;
    r = '0;
    ext     = lad[vref_pkg::LAD_SOURCE_BIT];
    cfg_p   = sel[vref_pkg::SEL_ADCP_BIT];
    cfg_n   = sel[vref_pkg::SEL_ADCN_BIT];
    pin_out = lad[vref_pkg::LAD_PIN_BIT] && !cfg_n;
    r.fixed_ref_on    = lat[vref_pkg::LAT_FIXED_BIT] || osc;
    r.ladder_power    = lad[vref_pkg::LAD_POWER_BIT];
    r.range_low       = lad[vref_pkg::LAD_RANGE_BIT];
    r.source_external = ext;
    r.tap             = lad[3:0];
    r.ladder_clamped  = !r.ladder_power && r.range_low && (r.tap == 4'h0);
    r.cmp1_ladder     = sel[vref_pkg::SEL_CMP1_BIT];
    r.cmp2_ladder     = sel[vref_pkg::SEL_CMP2_BIT];
    // Clamp setting wins so the zero-crossing mode draws no current
    r.ladder_current  = (r.cmp1_ladder || r.cmp2_ladder)
                        && !r.ladder_clamped;
    if (r.ladder_power) begin
      r.level = ladder_level(r.range_low, r.tap);
    end else begin
      r.level = 7'h00;
    end
    if (pin_out) begin
      r.pin2 = vref_pkg::PIN2_LADDER;
    end else if (ext || cfg_n) begin
      r.pin2 = vref_pkg::PIN2_VREF_NEG;
    end else begin
      r.pin2 = vref_pkg::PIN2_IO;
    end
    if (ext || cfg_p) begin
      r.pin3 = vref_pkg::PIN3_VREF_POS;
    end else begin
      r.pin3 = vref_pkg::PIN3_IO;
    end
    r.cmp_pos = ext ? vref_pkg::POS_EXTERNAL : vref_pkg::POS_SUPPLY;
    r.cmp_neg = (ext && !pin_out) ? vref_pkg::NEG_EXTERNAL
                                  : vref_pkg::NEG_GROUND;
    r.adc_pos = cfg_p ? vref_pkg::POS_EXTERNAL : vref_pkg::POS_SUPPLY;
    r.adc_neg = cfg_n ? vref_pkg::NEG_EXTERNAL : vref_pkg::NEG_GROUND;
    route_of = r;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic wr_en;
    wr_en = 1'b0;
    state_nxt = state_r;
    case (state_r.bus)
      vref_pkg::BUS_IDLE: begin
        if (read || write) begin
          state_nxt.bus      = vref_pkg::BUS_ACK;
          state_nxt.wait_req = 1'b0;
          state_nxt.rdata    = 32'h0000_0000;
          if (read) begin
            if (address == vref_pkg::OFS_LADDER) begin
              state_nxt.rdata[7:0] = state_r.ladder;
            end else if (address == vref_pkg::OFS_LATCH) begin
              state_nxt.rdata[7:0] = state_r.latch;
            end else if (address == vref_pkg::OFS_SELECT) begin
              state_nxt.rdata[3:0] = state_r.sel;
            end else if (address == vref_pkg::OFS_STATUS) begin
              state_nxt.rdata[0]    = state_r.rt.fixed_ref_on;
              state_nxt.rdata[1]    = state_r.rt.ladder_current;
              state_nxt.rdata[2]    = state_r.rt.ladder_power;
              state_nxt.rdata[3]    = state_r.rt.ladder_clamped;
              state_nxt.rdata[14:8] = state_r.rt.level;
            end
          end
        end
      end
      vref_pkg::BUS_ACK: begin
        state_nxt.bus      = vref_pkg::BUS_IDLE;
        state_nxt.wait_req = 1'b1;
        wr_en = write && byteenable[0];
      end
      default: begin
        state_nxt.bus      = vref_pkg::BUS_IDLE;
        state_nxt.wait_req = 1'b1;
      end
    endcase
    if (wr_en) begin
      if (address == vref_pkg::OFS_LADDER) begin
        state_nxt.ladder = writedata[7:0];
      end else if (address == vref_pkg::OFS_LATCH) begin
        // Pulse bits and the unused bit never hold a one
        state_nxt.latch = writedata[7:0] & vref_pkg::LATCH_RW_MASK;
      end else if (address == vref_pkg::OFS_SELECT) begin
        state_nxt.sel = writedata[3:0];
      end
    end
    state_nxt.rt = route_of(state_nxt.ladder, state_nxt.latch,
                            state_nxt.sel, fast_internal_osc_active);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r          <= '0;
      state_r.bus      <= vref_pkg::BUS_IDLE;
      state_r.wait_req <= 1'b1;
      state_r.ladder   <= vref_pkg::LADDER_RESET;
      state_r.latch    <= vref_pkg::LATCH_RESET;
      state_r.sel      <= vref_pkg::SELECT_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign readdata    = state_r.rdata;
  assign waitrequest = state_r.wait_req;
  assign route       = state_r.rt;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic wr_done;
  assign wr_done = write && !waitrequest && byteenable[0];

  a_fixed_enable_write: assert property (
    wr_done && address == vref_pkg::OFS_LATCH && writedata[0]
    |=> route.fixed_ref_on)
    else $error("fixed reference not on after enable write");

  a_osc_forces_fixed: assert property (
    fast_internal_osc_active |=> route.fixed_ref_on)
    else $error("fixed reference off while oscillator runs");

  a_fixed_off_cause: assert property (
    !$past(fast_internal_osc_active) && !state_r.latch[0]
    |-> !route.fixed_ref_on)
    else $error("fixed reference on without cause");

  a_cmp1_select_write: assert property (
    wr_done && address == vref_pkg::OFS_SELECT
    |=> route.cmp1_ladder == $past(writedata[0]))
    else $error("comparator 1 routing not updated");

  a_cmp2_select_write: assert property (
    wr_done && address == vref_pkg::OFS_SELECT
    |=> route.cmp2_ladder == $past(writedata[1]))
    else $error("comparator 2 routing not updated");

  a_current_off_idle: assert property (
    !route.cmp1_ladder && !route.cmp2_ladder |-> !route.ladder_current)
    else $error("ladder current with no comparator select");

  a_power_bit_write: assert property (
    wr_done && address == vref_pkg::OFS_LADDER
    |=> route.ladder_power == $past(writedata[7])
        && route.range_low == $past(writedata[5])
        && route.source_external == $past(writedata[4]))
    else $error("ladder control bits not applied");

  a_pin_two_drive: assert property (
    route.pin2 == vref_pkg::PIN2_LADDER
    |-> state_r.ladder[6] && !state_r.sel[3])
    else $error("pin two driven by ladder without cause");

  a_low_range_level: assert property (
    route.ladder_power && route.range_low
    |-> route.level == {1'b0, route.tap, 2'b00})
    else $error("low range level wrong");

  a_high_range_level: assert property (
    route.ladder_power && !route.range_low
    |-> route.level == 7'h18 + {3'h0, route.tap} * 7'h03)
    else $error("high range level wrong");

  a_adc_refs: assert property (
    wr_done && address == vref_pkg::OFS_SELECT
    |=> (route.adc_pos == vref_pkg::POS_EXTERNAL) == $past(writedata[2])
        && (route.adc_neg == vref_pkg::NEG_EXTERNAL) == $past(writedata[3]))
    else $error("ADC reference selection wrong");

  a_cmp_neg_ground: assert property (
    route.source_external && route.pin2 == vref_pkg::PIN2_LADDER
    |-> route.cmp_neg == vref_pkg::NEG_GROUND)
    else $error("comparator negative not grounded");

  a_clamp_no_current: assert property (
    route.ladder_clamped |-> route.level == 7'h00 && !route.ladder_current)
    else $error("clamped ladder not at ground");

  a_power_off_level: assert property (
    !route.ladder_power |-> route.level == 7'h00)
    else $error("ladder level not grounded while powered down");

  a_tap_write: assert property (
    wr_done && address == vref_pkg::OFS_LADDER
    |=> route.tap == $past(writedata[3:0]))
    else $error("ladder tap not applied");

  a_current_select: assert property (
    (route.cmp1_ladder || route.cmp2_ladder) && !route.ladder_clamped
    |-> route.ladder_current)
    else $error("ladder current off with comparator select");

  a_cmp_pos_source: assert property (
    (route.cmp_pos == vref_pkg::POS_EXTERNAL) == route.source_external)
    else $error("comparator positive reference wrong");

  a_pin_three_route: assert property (
    (route.pin3 == vref_pkg::PIN3_VREF_POS)
    == (route.source_external || route.adc_pos == vref_pkg::POS_EXTERNAL))
    else $error("pin three routing wrong");

  a_bus_one_wait: assert property (
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer timing wrong");

  c_fixed_by_osc: cover property (
    fast_internal_osc_active && !state_r.latch[0] ##1 route.fixed_ref_on);
  c_both_ladder: cover property (route.cmp1_ladder && route.cmp2_ladder);
  c_pin_out_ext: cover property (
    route.pin2 == vref_pkg::PIN2_LADDER && route.source_external);
  c_clamped: cover property (route.ladder_clamped);

endmodule

// ---- ref_user.sv ----
// Purpose: Far-side model that takes the selected references
// Assumes: Settling time counted in clock cycles
// Notes:   Behavioural; reports when the fixed reference may be trusted
`timescale 1ns/1ps

module ref_user #(
  parameter int SETTLE = 5
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire vref_pkg::route_s route,
  output logic                  fixed_ready
);
  int unsigned wait_cnt;

  // ==========================================================
  // Settling
  // No use of the fixed reference until a full settling run has passed
  always @(posedge clk) begin
    if (!reset_n || !route.fixed_ref_on) begin
      wait_cnt <= 0;
    end else if (wait_cnt < SETTLE) begin
      wait_cnt <= wait_cnt + 1;
    end
  end
  assign fixed_ready = (wait_cnt == SETTLE);
endmodule

// ---- voltage_reference_select_control_test.sv ----
// Purpose: Self-checking bench for the reference select control
// Assumes: Avalon-MM slave answers with waitrequest low
// Notes:   Register reads and route snapshots are checked from queues
`timescale 1ns/1ps

module voltage_reference_select_control_test;
  localparam int SETTLE = 5;
  logic             clk = 1'b0;
  logic             reset_n = 1'b0;
  logic             read = 1'b0;
  logic             write = 1'b0;
  logic             osc = 1'b0;
  logic [3:0]       address = 4'h0;
  logic [3:0]       byteenable = 4'hF;
  logic [31:0]      writedata = 32'h0;
  logic [31:0]      readdata;
  logic             waitrequest;
  logic             fixed_ready;
  logic             rt_chk = 1'b0;
  vref_pkg::route_s route;
  logic [31:0]      rd_q[$];
  logic [7:0]       rt_q[$];
  int               error_cnt = 0;
  int               checks_done = 0;
  int               i;
  logic [7:0]       v;
  logic [1:0]       p2;

  always #50 clk = ~clk;

  vref_select_ctl DUT (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .fast_internal_osc_active(osc), .route(route));
  ref_user #(.SETTLE(SETTLE)) user (.clk(clk), .reset_n(reset_n), .route(route),
    .fixed_ready(fixed_ready));

  // ==========================================================
  // Reporting
  task automatic close_out();
    // Notes still queued mean an expected answer never came
    if (rd_q.size() != 0 || rt_q.size() != 0) error_cnt++;
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_rd(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] readdata exp %h got %h", exp, got);
    end
  endtask

  task automatic chk_rt(input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] route exp %h got %h", exp, got);
    end
  endtask

  // ==========================================================
  // Bus master
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    @(posedge clk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    byteenable <= be;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    read <= 1'b0;
    write <= 1'b0;
    if (n == 20) begin
      error_cnt++;
      close_out();
    end
  endtask

  // Upper data bits and byte enables are random: only bit 0 and byte 0 count
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] x;
    x = $urandom();
    x[7:0] = d;
    bus(1'b1, a, x, {x[31:29], 1'b1});
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask

  task automatic xrt(input logic [7:0] e);
    repeat (2) @(posedge clk);
    rt_q.push_back(e);
    rt_chk <= 1'b1;
    @(posedge clk);
    rt_chk <= 1'b0;
  endtask

  function automatic logic [31:0] stat(logic fo, logic cur, logic pw, logic cl,
                                       logic [6:0] lvl);
    return {17'h0, lvl, 4'h0, cl, pw, cur, fo};
  endfunction

  // ==========================================================
  // Monitor
  always @(posedge clk) begin
    if (read && waitrequest === 1'b0 && rd_q.size() > 0) chk_rd(rd_q.pop_front(), readdata);
    if (rt_chk && rt_q.size() > 0) chk_rt(rt_q.pop_front(), {route.pin2, route.pin3,
      route.cmp_pos, route.cmp_neg, route.adc_pos, route.adc_neg, fixed_ready});
  end

  // ==========================================================
  // Main sequence
  initial begin
    i = $urandom(32'h4B90E455);
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (i = 0; i < 4; i++) rd(4'(i * 4), 32'h0);
    wr(4'h2, 8'hFF);
    wr(vref_pkg::OFS_STATUS, 8'hFF);
    rd(4'h2, 32'h0);
    rd(vref_pkg::OFS_STATUS, 32'h0);
    bus(1'b1, vref_pkg::OFS_LADDER, 32'hFF, 4'hE);
    rd(vref_pkg::OFS_LADDER, 32'h0);
    for (i = 0; i < 4; i++) begin
      v = 8'($urandom());
      wr(vref_pkg::OFS_LADDER, v);
      rd(vref_pkg::OFS_LADDER, {24'h0, v});
    end
    wr(vref_pkg::OFS_LADDER, 8'h00);
    wr(vref_pkg::OFS_LATCH, 8'hFF);
    rd(vref_pkg::OFS_LATCH, 32'hF1);
    rd(vref_pkg::OFS_STATUS, stat(1, 0, 0, 0, 0));
    repeat (SETTLE) @(posedge clk);
    xrt(8'h01);
    wr(vref_pkg::OFS_LATCH, 8'h00);
    rd(vref_pkg::OFS_STATUS, 32'h0);
    osc <= 1'b1;
    rd(vref_pkg::OFS_STATUS, stat(1, 0, 0, 0, 0));
    osc <= 1'b0;
    wr(vref_pkg::OFS_SELECT, 8'h01);
    for (i = 0; i < 32; i++) begin
      wr(vref_pkg::OFS_LADDER, {2'b10, i[4], 1'b0, i[3:0]});
      rd(vref_pkg::OFS_STATUS, stat(0, 1, 1, 0,
        7'(i[4] ? i[3:0] * 4 : 24 + i[3:0] * 3)));
    end
    wr(vref_pkg::OFS_LADDER, 8'h85);
    for (i = 0; i < 4; i++) begin
      wr(vref_pkg::OFS_SELECT, 8'(i));
      rd(vref_pkg::OFS_STATUS, stat(0, i != 0, 1, 0, 7'd39));
    end
    wr(vref_pkg::OFS_LADDER, 8'h20);
    rd(vref_pkg::OFS_STATUS, stat(0, 0, 0, 1, 0));
    wr(vref_pkg::OFS_LADDER, 8'h25);
    rd(vref_pkg::OFS_STATUS, stat(0, 1, 0, 0, 0));
    for (i = 0; i < 16; i++) begin
      wr(vref_pkg::OFS_SELECT, {4'h0, i[3], i[2], 2'b00});
      wr(vref_pkg::OFS_LADDER, {1'b1, i[0], 1'b0, i[1], 4'h0});
      p2 = (i[0] && !i[3]) ? vref_pkg::PIN2_LADDER :
           (i[1] || i[3]) ? vref_pkg::PIN2_VREF_NEG : vref_pkg::PIN2_IO;
      xrt({p2, i[1] | i[2], i[1], i[1] & !(i[0] & !i[3]), i[2], i[3], 1'b0});
    end
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (i = 0; i < 4; i++) rd(4'(i * 4), 32'h0);
    xrt(8'h00);
    repeat (2) @(posedge clk);
    close_out();
  end
endmodule
